// File: bench/parallel_flash_bus_operations_bench.sv
// Self-checking bench for the parallel flash host sequencer.
`timescale 1ns/1ps
module parallel_flash_bus_operations_bench;
  import pfh_pkg::*;
  // Autoselect command and code that the flash model answers with; both arbitrary.
  localparam logic [15:0] ID_CMD = 16'h00C7;
  localparam logic [7:0] ID_CODE = 8'h3C;
  typedef struct {pfh_op_type op; logic bm; logic [24:0] addr; logic [15:0] wd;
    int lat; logic refd; logic hv;} pfh_row_type;
  logic i_clock = 1'b0, i_rst = 1'b1, i_cke = 1'b1, i_req = 1'b0, i_byte_mode = 1'b0;
  pfh_op_type i_op = OP_READ;
  logic [24:0] i_addr = 25'h0000000;
  logic [15:0] i_wdata = 16'h0000, o_rdata, o_dq_out, o_dq_oe, dev_dq, dev_oe, dq_wire;
  logic [15:0] float_pat = 16'hA5A5;
  logic o_ready, o_done, o_refused, o_reissue, o_ce_n, o_oe_n, o_we_n, o_reset_n, o_byte_n;
  logic o_high_program_voltage, i_ready_busy, slow = 1'b0, freeze = 1'b0, lsb = 1'b0;
  logic seen_reissue = 1'b0;
  logic [23:0] o_addr;
  int mismatches = 0, num_checks = 0, low_cyc = 0;
  pfh_row_type rows [15];

  always #12.5 i_clock = ~i_clock;
  always @(posedge i_clock) float_pat <= ~float_pat;
  assign dq_wire = (o_dq_oe & o_dq_out) | (~o_dq_oe & dev_oe & dev_dq) |
    (~o_dq_oe & ~dev_oe & float_pat);

  pfh_host u_pfh_host (.i_clock(i_clock), .i_rst(i_rst), .i_cke(i_cke), .i_req(i_req),
    .i_op(i_op), .i_addr(i_addr), .i_wdata(i_wdata), .i_byte_mode(i_byte_mode),
    .o_ready(o_ready), .o_done(o_done), .o_refused(o_refused), .o_reissue(o_reissue),
    .o_rdata(o_rdata), .o_ce_n(o_ce_n), .o_oe_n(o_oe_n), .o_we_n(o_we_n),
    .o_reset_n(o_reset_n), .o_byte_n(o_byte_n),
    .o_high_program_voltage(o_high_program_voltage), .o_addr(o_addr),
    .o_dq_out(o_dq_out), .o_dq_oe(o_dq_oe), .i_dq_in(dq_wire), .i_ready_busy(i_ready_busy));
  pfh_flash_model #(.IDENT_CMD(ID_CMD), .IDENT_CODE(ID_CODE))
    u_pfh_flash_model (.i_ce_n(o_ce_n), .i_oe_n(o_oe_n), .i_we_n(o_we_n),
    .i_reset_n(o_reset_n), .i_byte_n(o_byte_n), .i_hv(o_high_program_voltage),
    .i_slow(slow), .i_addr(o_addr), .i_dq(dq_wire), .o_dq(dev_dq), .o_dq_oe(dev_oe),
    .o_ready_busy(i_ready_busy));

  // ----------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------
  task automatic check(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize

  task automatic give_up();
    mismatches++;
    $display("wrong value at %0t: no answer", $time);
    summarize();
  endtask : give_up

  function automatic logic [15:0] expect_rd(input logic bm, input logic [24:0] a);
    logic [15:0] w;
    w = (bm ? a[16:1] : a[15:0]) ^ 16'h5AC3;
    return bm ? {8'h00, (a[0] ? w[15:8] : w[7:0])} : w;
  endfunction : expect_rd

  // Requests are raised on a falling edge and counted in cycles after the take.
  task automatic do_op(input pfh_op_type op, input logic bm, input logic [24:0] a,
      input logic [15:0] wd, output int lat, output logic refd);
    // One spare edge keeps the request from being lowered and raised in one time step.
    @(negedge i_clock);
    for (int k = 0; o_ready !== 1'b1; k++) begin
      if (k > 100) give_up();
      @(negedge i_clock);
    end
    i_req = 1'b1;
    i_op = op;
    i_byte_mode = bm;
    i_addr = a;
    i_wdata = wd;
    lsb = a[0] & bm;
    @(negedge i_clock);
    i_req = 1'b0;
    for (lat = 1; o_done !== 1'b1 && o_refused !== 1'b1; lat++) begin
      if (lat > 200) give_up();
      i_cke = !(freeze && lat < 4);
      @(negedge i_clock);
    end
    i_cke = 1'b1;
    refd = o_refused;
  endtask : do_op

  // Pin discipline is watched on every cycle.
  always @(negedge i_clock) begin
    if (!i_rst && o_oe_n === 1'b0) begin
      check(o_we_n === 1'b1 && o_ce_n === 1'b0, "read strobes");
      check(o_high_program_voltage === 1'b0, "read under high voltage");
      check(o_dq_oe === (o_byte_n ? 16'h0000 : 16'h8000), "read drive");
      if (o_byte_n === 1'b0) check(o_dq_out[15] === lsb, "byte address bit");
    end
    if (!i_rst && o_we_n === 1'b0) begin
      check(o_oe_n === 1'b1 && o_ce_n === 1'b0, "write strobes");
      check(o_dq_oe === (i_byte_mode ? 16'h80FF : 16'hFFFF), "write drive");
      check(o_dq_out[7:0] === i_wdata[7:0], "write data");
    end
    if (!i_rst && (o_oe_n === 1'b0 || o_we_n === 1'b0))
      check(o_addr === (i_byte_mode ? i_addr[24:1] : i_addr[23:0]), "address pins");
    if (o_reissue === 1'b1) seen_reissue = 1'b1;
    if (o_reset_n === 1'b0) low_cyc++;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin : main
    int lat;
    logic refd;
    rows = '{'{OP_READ, 1'h0, 25'h10, 16'h0, 9, 1'h0, 1'h0},
      '{OP_READ, 1'h0, 25'h11, 16'h0, 7, 1'h0, 1'h0}, '{OP_READ, 1'h0, 25'h13, 16'h0, 7, 1'h0, 1'h0},
      '{OP_READ, 1'h0, 25'h14, 16'h0, 9, 1'h0, 1'h0}, '{OP_WRITE, 1'h0, 25'h555, 16'hAA, 5, 1'h0, 1'h0},
      '{OP_READ, 1'h0, 25'h15, 16'h0, 9, 1'h0, 1'h0}, '{OP_READ, 1'h1, 25'h2B, 16'h0, 9, 1'h0, 1'h0},
      '{OP_READ, 1'h1, 25'h2A, 16'h0, 7, 1'h0, 1'h0}, '{OP_READ, 1'h1, 25'h2C, 16'h0, 7, 1'h0, 1'h0},
      '{OP_ACC_ON, 1'h0, 25'h0, 16'h0, 1, 1'h0, 1'h1}, '{OP_READ, 1'h0, 25'h20, 16'h0, 1, 1'h1, 1'h1},
      '{OP_WRITE, 1'h0, 25'h20, 16'h1234, 5, 1'h0, 1'h1},
      '{OP_BUF_OPEN, 1'h0, 25'h0, 16'h0, 1, 1'h1, 1'h1}, '{OP_RESET, 1'h0, 25'h0, 16'h0, 1, 1'h1, 1'h1},
      '{OP_ACC_OFF, 1'h0, 25'h0, 16'h0, 1, 1'h0, 1'h0}};
    repeat (4) @(negedge i_clock);
    i_rst = 1'b0;
    @(negedge i_clock);
    check({o_ce_n, o_oe_n, o_we_n, o_reset_n, o_byte_n, o_high_program_voltage} === 6'h3E &&
      o_dq_oe === 16'h0000 && o_ready === 1'b1 && o_rdata === 16'h0000, "reset state");
    $display("reset state test done");
    foreach (rows[i]) begin
      do_op(rows[i].op, rows[i].bm, rows[i].addr, rows[i].wd, lat, refd);
      check(lat == rows[i].lat, "latency");
      check(refd === rows[i].refd, "refusal");
      check(o_high_program_voltage === rows[i].hv, "program voltage");
      if (rows[i].op == OP_READ && !refd)
        check(o_rdata === expect_rd(rows[i].bm, rows[i].addr), "read data");
      $display("row %0d done", i);
    end
    // The seventeenth word or thirty-third byte is the first one refused.
    for (int m = 0; m < 2; m++) begin
      do_op(OP_BUF_OPEN, m[0], 25'h100, 16'h0, lat, refd);
      for (int k = 0; k <= (m ? 32 : 16); k++) begin
        do_op(OP_BUF_LOAD, m[0], 25'h100 + 25'(k), 16'(k), lat, refd);
        check(refd === (k == (m ? 32 : 16)), "buffer limit");
      end
    end
    $display("buffer limit test done");
    freeze = 1'b1;
    do_op(OP_WRITE, 1'h0, 25'h200, 16'hBEEF, lat, refd);
    freeze = 1'b0;
    check(lat == 8, "frozen write");
    $display("clock enable test done");
    do_op(OP_WRITE, 1'h0, 25'h40, ID_CMD, lat, refd);
    do_op(OP_READ, 1'h0, 25'h41, 16'h0, lat, refd);
    check(o_rdata === {8'h00, ID_CODE}, "identification read");
    $display("autoselect test done");
    slow = 1'b1;
    do_op(OP_WRITE, 1'h1, 25'h301, 16'h5A, lat, refd);
    check(i_ready_busy === 1'b0 && o_ce_n === 1'b1, "busy after deselect");
    low_cyc = 0;
    do_op(OP_RESET, 1'h0, 25'h0, 16'h0, lat, refd);
    check(lat == 23 && low_cyc >= 20, "reset pulse");
    check(seen_reissue === 1'b1, "reissue flag");
    check(i_ready_busy === 1'b1, "abort");
    do_op(OP_READ, 1'h0, 25'h30, 16'h0, lat, refd);
    check(o_rdata === expect_rd(1'h0, 25'h30), "read after reset");
    $display("reset abort test done");
    summarize();
  end
endmodule : parallel_flash_bus_operations_bench

// File: bench/pfh_flash_model.sv
// Behavioural flash device that answers the host sequencer on its pins.
`timescale 1ns/1ps
module pfh_flash_model #(
  // Both values are arbitrary; they only need to match the bench.
  parameter logic [15:0] IDENT_CMD = 16'h00C7,
  parameter logic [7:0] IDENT_CODE = 8'h3C
) (
  input wire logic i_ce_n,
  input wire logic i_oe_n,
  input wire logic i_we_n,
  input wire logic i_reset_n,
  input wire logic i_byte_n,
  input wire logic i_hv,
  input wire logic i_slow,
  input wire logic [23:0] i_addr,
  input wire logic [15:0] i_dq,
  output logic [15:0] o_dq,
  output logic [15:0] o_dq_oe,
  output logic o_ready_busy
);
  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [15:0] word;
  logic [15:0] held = 16'h0000;
  logic [21:0] page = 22'h000000;
  logic fresh = 1'b1;
  logic ident = 1'b0;
  logic unprotect;
  realtime busy_end = 0.0;
  // The array is a fixed pattern, so any read outside identification mode must show it.
  assign word = i_addr[15:0] ^ 16'h5AC3;
  assign unprotect = i_hv;
  assign o_dq = held;
  assign o_dq_oe = (!i_ce_n && !i_oe_n && i_reset_n) ?
    (i_byte_n ? 16'hFFFF : 16'h00FF) : 16'h0000;
  // Old data is inverted until the access time runs out, so early sampling is caught.
  always @(i_addr or i_byte_n or negedge i_ce_n or (i_dq[15] & ~i_byte_n)) begin
    held <= ~held;
    held <= #((fresh || i_addr[23:2] != page) ? (i_slow ? 100 : 60) : (i_slow ? 30 : 15))
      (ident ? {8'h00, IDENT_CODE} :
      i_byte_n ? word : {8'h00, i_dq[15] ? word[15:8] : word[7:0]});
    page <= i_addr[23:2];
    fresh <= 1'b0;
  end
  always @(posedge i_ce_n or negedge i_reset_n) fresh <= 1'b1;
  // ----------------------------------------------------------------
  // Busy timing
  // ----------------------------------------------------------------
  always @(posedge i_we_n) begin
    if (!i_ce_n && i_oe_n && i_reset_n) busy_end = $realtime + (i_slow ? 3000.0 : 200.0);
    if (!i_ce_n && i_oe_n && i_reset_n && i_dq == IDENT_CMD) ident = 1'b1;
  end
  always @(negedge i_reset_n) begin
    busy_end = 0.0;
    ident = 1'b0;
  end
  always #5 o_ready_busy = ($realtime >= busy_end);
endmodule : pfh_flash_model

// File: shared/pfh_pkg.sv
// Constants, timing figures and enumerations for the parallel flash host.
package pfh_pkg;

  // ----------------------------------------------------------------
  // Bus widths and clock
  // ----------------------------------------------------------------
  localparam int PIN_ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int CLK_PERIOD_NS = 25;
  localparam int SYNC_STAGES = 2;
  localparam int TIMER_W = 8;

  // ----------------------------------------------------------------
  // Times in nanoseconds and their cycle counts
  // ----------------------------------------------------------------
  localparam int RANDOM_ACCESS_TIME_NS = 100;
  localparam int PAGE_ACCESS_TIME_NS = 30;
  localparam int SLEEP_EXTRA_NS = 30;
  localparam int CLEAR_PULSE_MIN_WIDTH_NS = 500;
  localparam int WRITE_PULSE_NS = 50;
  localparam int RESET_RECOVER_NS = 50;

  function automatic int pfh_ns_to_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : pfh_ns_to_cycles

  localparam logic [TIMER_W-1:0] RANDOM_ACCESS_CYC =
    TIMER_W'(pfh_ns_to_cycles(RANDOM_ACCESS_TIME_NS) + SYNC_STAGES);
  localparam logic [TIMER_W-1:0] PAGE_ACCESS_CYC =
    TIMER_W'(pfh_ns_to_cycles(PAGE_ACCESS_TIME_NS) + SYNC_STAGES);
  localparam logic [TIMER_W-1:0] CLEAR_PULSE_CYC =
    TIMER_W'(pfh_ns_to_cycles(CLEAR_PULSE_MIN_WIDTH_NS));
  localparam logic [TIMER_W-1:0] WRITE_PULSE_CYC = TIMER_W'(pfh_ns_to_cycles(WRITE_PULSE_NS));
  localparam logic [TIMER_W-1:0] RESET_RECOVER_CYC =
    TIMER_W'(pfh_ns_to_cycles(RESET_RECOVER_NS));

  // ----------------------------------------------------------------
  // Write buffer limits and reset values
  // ----------------------------------------------------------------
  localparam logic [5:0] BUF_MAX_WORDS = 6'h10;
  localparam logic [5:0] BUF_MAX_BYTES = 6'h20;
  localparam logic [15:0] RDATA_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Requests and states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_READ = 3'h0,
    OP_WRITE = 3'h1,
    OP_BUF_OPEN = 3'h2,
    OP_BUF_LOAD = 3'h3,
    OP_RESET = 3'h4,
    OP_ACC_ON = 3'h5,
    OP_ACC_OFF = 3'h6
  } pfh_op_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_STROBE = 3'b011,
    ST_HOLD = 3'b010,
    ST_CLEAR = 3'b110,
    ST_RECOVER = 3'b111
  } pfh_state_type;

endpackage : pfh_pkg

// File: shared/pfh_timer_if.sv
// Interface between the host sequencer and its cycle timer.
`timescale 1ns/1ps
interface pfh_timer_if;
  logic load;
  logic [pfh_pkg::TIMER_W-1:0] count;
  logic done;
  modport ctrl (output load, output count, input done);
  modport tmr (input load, input count, output done);
endinterface : pfh_timer_if

// File: verilog/pfh_host.sv
// Host-side sequencer that drives the parallel flash pins.
`timescale 1ns/1ps
module pfh_host (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_cke,
  input wire logic i_req,
  input wire pfh_pkg::pfh_op_type i_op,
  input wire logic [pfh_pkg::PIN_ADDR_W:0] i_addr,
  input wire logic [pfh_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_byte_mode,
  output logic o_ready,
  output logic o_done,
  output logic o_refused,
  output logic o_reissue,
  output logic [pfh_pkg::DATA_W-1:0] o_rdata,
  output logic o_ce_n,
  output logic o_oe_n,
  output logic o_we_n,
  output logic o_reset_n,
  output logic o_byte_n,
  output logic o_high_program_voltage,
  output logic [pfh_pkg::PIN_ADDR_W-1:0] o_addr,
  output logic [pfh_pkg::DATA_W-1:0] o_dq_out,
  output logic [pfh_pkg::DATA_W-1:0] o_dq_oe,
  input wire logic [pfh_pkg::DATA_W-1:0] i_dq_in,
  input wire logic i_ready_busy
);
  import pfh_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] dq_meta;
  logic [DATA_W-1:0] dq_sync;
  logic rb_meta;
  logic rb_sync;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      dq_meta <= '0;
      dq_sync <= '0;
      rb_meta <= 1'b1;
      rb_sync <= 1'b1;
    end else if (i_cke) begin
      dq_meta <= i_dq_in;
      dq_sync <= dq_meta;
      rb_meta <= i_ready_busy;
      rb_sync <= rb_meta;
    end
  end

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  pfh_state_type state;
  pfh_op_type op;
  logic acc_on;
  logic page_open;
  logic [PIN_ADDR_W-1:2] page_tag;
  logic [5:0] buf_cnt;
  logic read_hit;
  pfh_timer_if tif ();

  pfh_timer u_timer (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_cke(i_cke),
    .t(tif.tmr)
  );

  wire take = i_req && o_ready && (state == ST_IDLE);
  wire is_read = (i_op == OP_READ);
  wire is_write = (i_op == OP_WRITE) || (i_op == OP_BUF_OPEN) || (i_op == OP_BUF_LOAD);
  wire [5:0] buf_limit = i_byte_mode ? BUF_MAX_BYTES : BUF_MAX_WORDS;
  // Anything but a plain program write or OP_ACC_OFF while high voltage is on could damage the part.
  wire acc_block = acc_on && (i_op != OP_WRITE) && (i_op != OP_ACC_OFF);
  wire buf_full = (i_op == OP_BUF_LOAD) && (buf_cnt >= buf_limit);
  wire refuse = acc_block || buf_full;
  wire [PIN_ADDR_W-1:0] pin_addr = i_byte_mode ? i_addr[PIN_ADDR_W:1] : i_addr[PIN_ADDR_W-1:0];
  // Only same-page reads with select held low may use the short time.
  wire page_hit = page_open && (pin_addr[PIN_ADDR_W-1:2] == page_tag)
    && (i_byte_mode == !o_byte_n);
  // The hit is latched at the take, because the width pin has moved by the time the timer loads.
  wire [TIMER_W-1:0] read_cyc = read_hit ? PAGE_ACCESS_CYC : RANDOM_ACCESS_CYC;
  wire start = take && !refuse;
  wire op_read = (op == OP_READ);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  pfh_state_type next_state;
  always_comb begin
    next_state = state;
    tif.load = 1'b0;
    tif.count = '0;
    unique case (state)
      ST_IDLE: begin
        if (start && (is_read || is_write)) begin
          next_state = ST_SETUP;
        end else if (start && (i_op == OP_RESET)) begin
          next_state = ST_CLEAR;
          tif.load = 1'b1;
          tif.count = CLEAR_PULSE_CYC;
        end
      end
      ST_SETUP: begin
        next_state = ST_STROBE;
        tif.load = 1'b1;
        tif.count = op_read ? read_cyc : WRITE_PULSE_CYC;
      end
      ST_STROBE: begin
        if (tif.done) begin
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        next_state = ST_IDLE;
      end
      ST_CLEAR: begin
        if (tif.done) begin
          next_state = ST_RECOVER;
          tif.load = 1'b1;
          tif.count = RESET_RECOVER_CYC;
        end
      end
      ST_RECOVER: begin
        if (tif.done) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state <= ST_IDLE;
      op <= OP_READ;
      read_hit <= 1'b0;
    end else if (i_cke) begin
      state <= next_state;
      if (take) begin
        op <= i_op;
        read_hit <= page_hit;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_ce_n <= 1'b1;
      o_oe_n <= 1'b1;
      o_we_n <= 1'b1;
      o_reset_n <= 1'b1;
      o_byte_n <= 1'b1;
      o_addr <= '0;
      o_dq_out <= '0;
      o_dq_oe <= '0;
    end else if (i_cke) begin
      if (start && (is_read || is_write)) begin
        o_ce_n <= 1'b0;
        o_byte_n <= !i_byte_mode;
        o_addr <= pin_addr;
        o_dq_out <= i_byte_mode ? {i_addr[0], 7'h00, i_wdata[7:0]} : i_wdata;
        o_dq_oe <= i_byte_mode ? 16'h8000 : 16'h0000;
      end else if (start && (i_op == OP_RESET)) begin
        o_ce_n <= 1'b1;
        o_reset_n <= 1'b0;
      end
      if (state == ST_SETUP) begin
        o_oe_n <= !op_read;
        o_we_n <= op_read;
        if (!op_read) begin
          o_dq_oe <= (!o_byte_n) ? 16'h80FF : 16'hFFFF;
        end
      end
      if (state == ST_STROBE && tif.done) begin
        o_oe_n <= 1'b1;
        o_we_n <= 1'b1;
      end
      // Select stays low after a read so that the next read may hit the page.
      if (state == ST_HOLD && !op_read) begin
        o_ce_n <= 1'b1;
        o_dq_oe <= '0;
      end
      if (state == ST_CLEAR && tif.done) begin
        o_reset_n <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status, data and bookkeeping
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_ready <= 1'b1;
      o_done <= 1'b0;
      o_refused <= 1'b0;
      o_reissue <= 1'b0;
      o_rdata <= RDATA_RESET;
      o_high_program_voltage <= 1'b0;
      acc_on <= 1'b0;
      page_open <= 1'b0;
      page_tag <= '0;
      buf_cnt <= '0;
    end else if (i_cke) begin
      o_done <= 1'b0;
      o_refused <= take && refuse;
      o_reissue <= take && !refuse && (i_op == OP_RESET) && !rb_sync;
      o_ready <= (next_state == ST_IDLE);
      if (start && (i_op == OP_ACC_ON || i_op == OP_ACC_OFF)) begin
        acc_on <= (i_op == OP_ACC_ON);
        o_high_program_voltage <= (i_op == OP_ACC_ON);
        o_done <= 1'b1;
      end
      if (start && (i_op == OP_BUF_OPEN || i_op == OP_RESET)) begin
        buf_cnt <= '0;
      end else if (start && i_op == OP_BUF_LOAD) begin
        buf_cnt <= buf_cnt + 6'h01;
      end
      if (state == ST_STROBE && tif.done && op_read) begin
        o_rdata <= (!o_byte_n) ? {8'h00, dq_sync[7:0]} : dq_sync;
        page_open <= 1'b1;
        page_tag <= o_addr[PIN_ADDR_W-1:2];
      end
      // Any write or reset raises select, so the next read pays full time again.
      if ((start && !is_read) || (state == ST_HOLD && !op_read)) begin
        page_open <= 1'b0;
      end
      if ((state == ST_HOLD) || (state == ST_RECOVER && tif.done)) begin
        o_done <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst || !i_cke);

  a_read_strobe_high: assert property (!o_oe_n |-> !o_ce_n && o_we_n)
    else $error("output gate low without select or with write strobe low");
  a_write_gate_high: assert property (!o_we_n |-> !o_ce_n && o_oe_n)
    else $error("write strobe low without select or with output gate low");
  a_byte_lane_drive: assert property (!o_byte_n && !o_ce_n |-> o_dq_oe[15] && o_dq_oe[14:8] == 7'h00)
    else $error("byte width lanes driven wrongly");
  a_write_two_step: assert property (start && i_op == OP_WRITE |=> o_we_n ##1 !o_we_n [*2] ##1 o_we_n)
    else $error("write strobe pulse shape wrong");
  a_buf_refuse: assert property (take && i_op == OP_BUF_LOAD && buf_cnt >= buf_limit |=> o_refused && o_ce_n == $past(o_ce_n))
    else $error("write buffer overflow not refused");
  a_acc_read_block: assert property (take && acc_on && i_op == OP_READ |=> o_refused && o_oe_n)
    else $error("read allowed while high voltage on");
  a_clear_width: assert property ($fell(o_reset_n) |-> !o_reset_n [*8] ##12 !o_reset_n ##1 o_reset_n)
    else $error("reset pulse width wrong");
  a_reissue_flag: assert property (take && i_op == OP_RESET && !acc_on && !rb_sync |=> o_reissue && !o_reset_n)
    else $error("interrupted operation not flagged");

  c_page_hit: cover property (take && is_read && page_hit);
  c_write_done: cover property (state == ST_HOLD && !op_read);
  c_reset_done: cover property (state == ST_RECOVER && tif.done);
  c_buf_refused: cover property (take && buf_full);

endmodule : pfh_host

// File: verilog/pfh_timer.sv
// Down-counter that flags the last cycle of a loaded interval.
`timescale 1ns/1ps
module pfh_timer (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_cke,
  pfh_timer_if.tmr t
);
  import pfh_pkg::*;

  logic [TIMER_W-1:0] cnt;

  // A load of N makes done show in the Nth cycle after the load.
  // Done must not look at load: the sequencer reloads on done, which would close a loop.
  assign t.done = (cnt == TIMER_W'(1));

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      cnt <= '0;
    end else if (i_cke) begin
      if (t.load) begin
        cnt <= t.count;
      end else if (cnt != '0) begin
        cnt <= cnt - TIMER_W'(1);
      end
    end
  end

endmodule : pfh_timer
